// ==== hdl/edi_pkg.sv ====
package edi_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [15:0] IDX_SUP_ALARM = 16'h6504;
    localparam logic [15:0] IDX_WARN = 16'h6505;
    localparam logic [15:0] IDX_SUP_WARN = 16'h6506;
    localparam logic [15:0] IDX_VERSION = 16'h6507;
    localparam logic [15:0] IDX_OP_TIME = 16'h6508;
    localparam logic [15:0] IDX_OFFSET = 16'h6509;
    localparam logic [15:0] IDX_MODID_MAX_SUB = 16'h650A;
    localparam logic [15:0] IDX_SERIAL = 16'h650B;
    // own registers
    localparam logic [15:0] IDX_MODID_MFR_OFS = 16'h6510;
    localparam logic [15:0] IDX_MODID_MIN = 16'h6511;
    localparam logic [15:0] IDX_MODID_MAX = 16'h6512;
    localparam logic [15:0] IDX_IDENT_SERIAL = 16'h6513;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'h6520;
    localparam logic [15:0] IDX_IRQ_ENABLE = 16'h6521;
    localparam logic [15:0] IDX_IRQ_CLEAR = 16'h6522;
    localparam logic [15:0] IDX_ERR_INFO = 16'h6523;
    localparam logic [15:0] SUP_ALARM_VAL = 16'h1000;
    localparam logic [15:0] SUP_WARN_VAL = 16'h1000;
    localparam logic [31:0] OP_TIME_VAL = 32'h0FFFFFFF;
    localparam logic [31:0] MODID_MAX_SUB_VAL = 32'h00000003;
    localparam int MAKER_LO = 12;
    localparam int MAKER_HI = 15;
    localparam int POS_ERR_BIT = 0;
    localparam int COMM_DIAG_BIT = 1;
    // irq status bits
    localparam int IRQ_WARN_SET = 0;
    localparam int IRQ_WARN_CLR = 1;
    localparam int IRQ_WR_REJ = 2;
    localparam int IRQ_W = 3;
endpackage : edi_pkg

// ==== hdl/edi_regs.sv ====
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module edi_regs #(
    parameter logic [7:0] SW_VER_UPPER = 8'h01, // arbitrary value
    parameter logic [7:0] SW_VER_LOWER = 8'h00, // arbitrary value
    parameter logic [7:0] PROF_VER_UPPER = 8'h01, // arbitrary value
    parameter logic [7:0] PROF_VER_LOWER = 8'h00 // arbitrary value
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] maker_defined_flag,
    input wire logic [1:0] alarm_source,
    input wire logic [31:0] preset_offset,
    input wire logic [31:0] mfr_offset,
    input wire logic [31:0] mfr_min_pos,
    input wire logic [31:0] mfr_max_pos,
    input wire logic [31:0] serial_in,
    output logic [15:0] warning_word,
    output logic [15:0] alarm_word,
    output logic [31:0] ident_serial,
    output logic irq
);
    typedef struct packed {
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic [15:0] warn;
        logic [15:0] alarm;
        logic [31:0] serial;
        logic [edi_pkg::IRQ_W-1:0] status;
        logic [edi_pkg::IRQ_W-1:0] enable;
        logic [15:0] last_err_idx;
        logic irq;
    } edi_state_type;

    edi_state_type st_r;
    edi_state_type st_nxt;

    function automatic logic [15:0] word_index(input logic [17:0] a);
        word_index = a[17:2];
    endfunction : word_index

    function automatic logic [15:0] make_warn(input logic [3:0] maker);
        logic [15:0] w;
        w = 16'h0000;
        w[edi_pkg::MAKER_HI:edi_pkg::MAKER_LO] = maker;
        make_warn = w;
    endfunction : make_warn

    logic setup;
    logic [15:0] idx;
    logic [15:0] new_warn;
    logic [edi_pkg::IRQ_W-1:0] ev;
    logic [edi_pkg::IRQ_W-1:0] clr;
    logic status_has_rej;
    logic rd_setup;
    logic wr_setup;
    logic wr_reject;

    assign setup = psel && !penable;
    assign idx = word_index(paddr);
    assign new_warn = make_warn(maker_defined_flag);
    assign status_has_rej = st_r.status[edi_pkg::IRQ_WR_REJ];
    assign rd_setup = setup && !pwrite;
    assign wr_setup = setup && pwrite;
    assign wr_reject = wr_setup && idx != edi_pkg::IDX_IRQ_ENABLE && idx != edi_pkg::IDX_IRQ_CLEAR;

    always_comb begin
        st_nxt = st_r;
        ev = '0;
        clr = '0;
        st_nxt.warn = new_warn;
        st_nxt.alarm = 16'h0000;
        st_nxt.alarm[edi_pkg::POS_ERR_BIT] = alarm_source[0];
        st_nxt.alarm[edi_pkg::COMM_DIAG_BIT] = alarm_source[1];
        st_nxt.serial = serial_in;
        ev[edi_pkg::IRQ_WARN_SET] = (new_warn & ~st_r.warn) != 16'h0000;
        ev[edi_pkg::IRQ_WARN_CLR] = (st_r.warn != 16'h0000) && (new_warn == 16'h0000);
        st_nxt.ready = 1'b0;
        st_nxt.err = 1'b0;
        st_nxt.rdata = 32'h00000000;
        if (setup) begin
            st_nxt.ready = 1'b1;
            if (pwrite) begin
                if (idx == edi_pkg::IDX_IRQ_ENABLE) begin
                    if (pstrb[0]) begin
                        st_nxt.enable = pwdata[edi_pkg::IRQ_W-1:0];
                    end
                end else if (idx == edi_pkg::IDX_IRQ_CLEAR) begin
                    if (pstrb[0]) begin
                        clr = pwdata[edi_pkg::IRQ_W-1:0];
                    end
                end else begin
                    st_nxt.err = 1'b1;
                    ev[edi_pkg::IRQ_WR_REJ] = 1'b1;
                    st_nxt.last_err_idx = idx;
                end
            end else begin
                case (idx)
                    edi_pkg::IDX_SUP_ALARM: st_nxt.rdata = {16'h0000, edi_pkg::SUP_ALARM_VAL};
                    edi_pkg::IDX_WARN: st_nxt.rdata = {16'h0000, st_r.warn};
                    edi_pkg::IDX_SUP_WARN: st_nxt.rdata = {16'h0000, edi_pkg::SUP_WARN_VAL};
                    edi_pkg::IDX_VERSION: begin
                        st_nxt.rdata = {SW_VER_UPPER, SW_VER_LOWER, PROF_VER_UPPER, PROF_VER_LOWER};
                    end
                    edi_pkg::IDX_OP_TIME: st_nxt.rdata = edi_pkg::OP_TIME_VAL;
                    edi_pkg::IDX_OFFSET: st_nxt.rdata = preset_offset;
                    edi_pkg::IDX_MODID_MAX_SUB: st_nxt.rdata = edi_pkg::MODID_MAX_SUB_VAL;
                    edi_pkg::IDX_MODID_MFR_OFS: st_nxt.rdata = mfr_offset;
                    edi_pkg::IDX_MODID_MIN: st_nxt.rdata = mfr_min_pos;
                    edi_pkg::IDX_MODID_MAX: st_nxt.rdata = mfr_max_pos;
                    edi_pkg::IDX_SERIAL: st_nxt.rdata = st_r.serial;
                    edi_pkg::IDX_IDENT_SERIAL: st_nxt.rdata = st_r.serial;
                    edi_pkg::IDX_IRQ_STATUS: st_nxt.rdata = {{(32-edi_pkg::IRQ_W){1'b0}}, st_r.status};
                    edi_pkg::IDX_IRQ_ENABLE: st_nxt.rdata = {{(32-edi_pkg::IRQ_W){1'b0}}, st_r.enable};
                    edi_pkg::IDX_IRQ_CLEAR: st_nxt.rdata = 32'h00000000;
                    edi_pkg::IDX_ERR_INFO: st_nxt.rdata = {16'h0000, st_r.last_err_idx};
                    default: begin
                        st_nxt.err = 1'b1;
                    end
                endcase
            end
        end
        // set wins over clear
        st_nxt.status = (st_r.status & ~clr) | ev;
        st_nxt.irq = (st_nxt.status & st_nxt.enable) != '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.rdata;
    assign pready = st_r.ready;
    assign pslverr = st_r.err;
    assign warning_word = st_r.warn;
    assign alarm_word = st_r.alarm;
    assign ident_serial = st_r.serial;
    assign irq = st_r.irq;

    a_sup_alarm_read: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && idx == edi_pkg::IDX_SUP_ALARM) |=> (prdata == 32'h00001000 && pready))
        else $error("supported alarms word wrong");
    a_std_warn_zero: assert property (@(posedge pclk) disable iff (!presetn)
        warning_word[11:0] == 12'h000)
        else $error("standard warning bit raised");
    a_warn_follow: assert property (@(posedge pclk) disable iff (!presetn)
        (maker_defined_flag == 4'h0) |=> (warning_word == 16'h0000))
        else $error("warnings not cleared");
    a_sup_warn_read: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && idx == edi_pkg::IDX_SUP_WARN) |=> (prdata == 32'h00001000))
        else $error("supported warnings word wrong");
    a_version_pack: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && idx == edi_pkg::IDX_VERSION) |=> (prdata[31:24] == SW_VER_UPPER
        && prdata[7:0] == PROF_VER_LOWER))
        else $error("version word packing wrong");
    a_op_time: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && idx == edi_pkg::IDX_OP_TIME) |=> (prdata == 32'h0FFFFFFF))
        else $error("operating time not constant");
    a_offset_read: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && idx == edi_pkg::IDX_OFFSET) |=> (prdata == $past(preset_offset)))
        else $error("offset value mismatch");
    a_modid_sub: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && idx == edi_pkg::IDX_MODID_MAX_SUB) |=> (prdata == 32'h00000003))
        else $error("highest subindex not 3");
    a_serial_same: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && (idx == edi_pkg::IDX_SERIAL || idx == edi_pkg::IDX_IDENT_SERIAL))
        |=> (prdata == ident_serial))
        else $error("serial number mismatch");
    a_alarm_map: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (alarm_word[1:0] == $past(alarm_source) && alarm_word[15:2] == 14'h0000))
        else $error("alarm word mapping wrong");
    a_ro_write_err: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && pwrite && idx != edi_pkg::IDX_IRQ_ENABLE && idx != edi_pkg::IDX_IRQ_CLEAR)
        |=> (pslverr && pready) ##1 status_has_rej)
        else $error("read-only write not refused");

    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready
        |=> !pready)
        else $error("ready longer than one cycle");

    a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
        setup
        |=> pready)
        else $error("no answer after setup");

    a_ready_cause: assert property (@(posedge pclk) disable iff (!presetn)
        pready
        |-> $past(setup))
        else $error("ready without setup");

    a_err_needs_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr
        |-> pready)
        else $error("error without ready");

    a_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !pready
        |-> (prdata == 32'h00000000))
        else $error("read data not zero while idle");

    a_unmapped_read: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_setup && idx > edi_pkg::IDX_ERR_INFO)
        |=> (pslverr && prdata == 32'h00000000))
        else $error("unmapped read not refused");

    a_mapped_read_ok: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_setup && idx == edi_pkg::IDX_SUP_ALARM)
        |=> !pslverr)
        else $error("mapped read refused");

    a_ro_enable_kept: assert property (@(posedge pclk) disable iff (!presetn)
        wr_reject
        |=> (st_r.enable == $past(st_r.enable)))
        else $error("refused write changed enable");

    a_ro_err_info: assert property (@(posedge pclk) disable iff (!presetn)
        wr_reject
        |=> (st_r.last_err_idx == $past(idx)))
        else $error("refused index not recorded");

    a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_setup && idx == edi_pkg::IDX_IRQ_ENABLE && pstrb[0])
        |=> (st_r.enable == $past(pwdata[edi_pkg::IRQ_W-1:0])))
        else $error("enable write lost");

    a_clear_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_setup && idx == edi_pkg::IDX_IRQ_CLEAR && pstrb[0] && ev == '0)
        |=> ((st_r.status & $past(pwdata[edi_pkg::IRQ_W-1:0])) == '0))
        else $error("status clear lost");

    a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        (ev != '0)
        |=> ((st_r.status & $past(ev)) == $past(ev)))
        else $error("event lost against clear");

    a_status_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (clr == '0)
        |=> ((st_r.status & $past(st_r.status)) == $past(st_r.status)))
        else $error("status bit dropped");

    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1
        |-> (irq == ((st_r.status & st_r.enable) != '0)))
        else $error("interrupt level wrong");

    a_warn_rise_flag: assert property (@(posedge pclk) disable iff (!presetn)
        ((new_warn & ~st_r.warn) != 16'h0000)
        |=> st_r.status[edi_pkg::IRQ_WARN_SET])
        else $error("warning rise not flagged");

    a_warn_gone_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r.warn != 16'h0000 && new_warn == 16'h0000)
        |=> st_r.status[edi_pkg::IRQ_WARN_CLR])
        else $error("warning clear not flagged");

    a_warn_maker: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1
        |=> (warning_word[15:12] == $past(maker_defined_flag)))
        else $error("maker warnings misplaced");

    a_warn_sample: assert property (@(posedge pclk) disable iff (!presetn)
        (maker_defined_flag != 4'h0)
        |=> (warning_word != 16'h0000))
        else $error("warning not raised");

    a_warn_read: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_setup && idx == edi_pkg::IDX_WARN)
        |=> (prdata == {16'h0000, $past(warning_word)}))
        else $error("warnings word read wrong");

    a_version_mid: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_setup && idx == edi_pkg::IDX_VERSION)
        |=> (prdata[23:16] == SW_VER_LOWER && prdata[15:8] == PROF_VER_UPPER))
        else $error("version middle bytes wrong");

    a_mfr_offset: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_setup && idx == edi_pkg::IDX_MODID_MFR_OFS)
        |=> (prdata == $past(mfr_offset)))
        else $error("manufacturer offset wrong");

    a_mfr_min: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_setup && idx == edi_pkg::IDX_MODID_MIN)
        |=> (prdata == $past(mfr_min_pos)))
        else $error("minimum position wrong");

    a_mfr_max: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_setup && idx == edi_pkg::IDX_MODID_MAX)
        |=> (prdata == $past(mfr_max_pos)))
        else $error("maximum position wrong");

    a_serial_copy: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1
        |=> (ident_serial == $past(serial_in)))
        else $error("serial copy wrong");

    a_serial_entry: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_setup && idx == edi_pkg::IDX_SERIAL)
        |=> (prdata == $past(ident_serial)))
        else $error("serial entry wrong");

    a_status_read: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_setup && idx == edi_pkg::IDX_IRQ_STATUS)
        |=> (prdata == {{(32-edi_pkg::IRQ_W){1'b0}}, $past(st_r.status)}))
        else $error("status read wrong");

    a_enable_read: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_setup && idx == edi_pkg::IDX_IRQ_ENABLE)
        |=> (prdata == {{(32-edi_pkg::IRQ_W){1'b0}}, $past(st_r.enable)}))
        else $error("enable read wrong");

    a_clear_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_setup && idx == edi_pkg::IDX_IRQ_CLEAR)
        |=> (prdata == 32'h00000000))
        else $error("clear register not zero");

    c_read_warn: cover property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && idx == edi_pkg::IDX_WARN && warning_word != 16'h0000);
    c_ro_write: cover property (@(posedge pclk) disable iff (!presetn) pslverr && pready);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    c_serial: cover property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && idx == edi_pkg::IDX_IDENT_SERIAL);
    c_warn_gone: cover property (@(posedge pclk) disable iff (!presetn)
        st_r.status[edi_pkg::IRQ_WARN_CLR]);
endmodule : edi_regs
`default_nettype wire

// ==== tb/edi_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module edi_master_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [17:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 18'h0;
        pwdata = 32'h0;
    end
    // one transfer: setup, access held until pready, release
    task automatic xfer(input logic we, input logic [15:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= we;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~wd;
        @(posedge pclk);
    endtask : xfer
endmodule : edi_master_model
`default_nettype wire

// ==== tb/test_encoder_diag_ident_objects.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_encoder_diag_ident_objects;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, preset_offset, mfr_offset, mfr_min_pos, mfr_max_pos, serial_in, ident_serial, rd;
    logic [3:0] maker_defined_flag;
    logic [1:0] alarm_source;
    logic [15:0] warning_word, alarm_word;
    int n_errors = 0;
    int cmp_count = 0;
    edi_regs #(.SW_VER_UPPER(8'h21), .SW_VER_LOWER(8'h43), .PROF_VER_UPPER(8'h65), .PROF_VER_LOWER(8'h87)) edi_regs_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .maker_defined_flag(maker_defined_flag), .alarm_source(alarm_source), .preset_offset(preset_offset),
        .mfr_offset(mfr_offset), .mfr_min_pos(mfr_min_pos), .mfr_max_pos(mfr_max_pos), .serial_in(serial_in),
        .warning_word(warning_word), .alarm_word(alarm_word), .ident_serial(ident_serial), .irq(irq));
    edi_master_model edi_master_model_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic we, input logic [15:0] idx, input logic [31:0] d, input logic [31:0] exp,
                       input logic e);
        edi_master_model_i.xfer(we, idx, d, rd, err);
        chk({31'h0, err}, {31'h0, e});
        if (!we) chk(rd, exp);
    endtask : acc
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    task automatic report_and_stop;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        tick(5000);
        n_errors++;
        report_and_stop();
    end
    initial begin
        presetn = 1'b0;
        maker_defined_flag = 4'h0;
        alarm_source = 2'h0;
        preset_offset = 32'hFFFFFF85;
        mfr_offset = 32'h00000123;
        mfr_min_pos = 32'hFFFFF000;
        mfr_max_pos = 32'h0003FFFF;
        serial_in = 32'h5A17C0DE;
        tick(10);
        presetn <= 1'b1;
        tick(1);
        acc(1'b0, edi_pkg::IDX_SUP_ALARM, 32'h0, 32'h00001000, 1'b0);
        acc(1'b0, edi_pkg::IDX_SUP_WARN, 32'h0, 32'h00001000, 1'b0);
        acc(1'b0, edi_pkg::IDX_VERSION, 32'h0, 32'h21436587, 1'b0);
        acc(1'b0, edi_pkg::IDX_OP_TIME, 32'h0, 32'h0FFFFFFF, 1'b0);
        acc(1'b0, edi_pkg::IDX_OFFSET, 32'h0, preset_offset, 1'b0);
        acc(1'b0, edi_pkg::IDX_MODID_MAX_SUB, 32'h0, 32'h00000003, 1'b0);
        acc(1'b0, edi_pkg::IDX_MODID_MFR_OFS, 32'h0, mfr_offset, 1'b0);
        acc(1'b0, edi_pkg::IDX_MODID_MIN, 32'h0, mfr_min_pos, 1'b0);
        acc(1'b0, edi_pkg::IDX_MODID_MAX, 32'h0, mfr_max_pos, 1'b0);
        acc(1'b0, edi_pkg::IDX_SERIAL, 32'h0, serial_in, 1'b0);
        acc(1'b0, edi_pkg::IDX_IDENT_SERIAL, 32'h0, serial_in, 1'b0);
        chk(ident_serial, serial_in);
        acc(1'b0, 16'h6600, 32'h0, 32'h0, 1'b1);
        acc(1'b0, edi_pkg::IDX_IRQ_CLEAR, 32'h0, 32'h0, 1'b0);
        // warning raise, interrupt, clear, mask
        acc(1'b1, edi_pkg::IDX_IRQ_ENABLE, 32'h7, 32'h0, 1'b0);
        maker_defined_flag <= 4'hA;
        tick(3);
        chk(warning_word, 32'h0000A000);
        chk(irq, 32'h1);
        acc(1'b0, edi_pkg::IDX_WARN, 32'h0, 32'h0000A000, 1'b0);
        acc(1'b0, edi_pkg::IDX_IRQ_STATUS, 32'h0, 32'h1, 1'b0);
        acc(1'b1, edi_pkg::IDX_IRQ_CLEAR, 32'h1, 32'h0, 1'b0);
        tick(2);
        chk(irq, 32'h0);
        maker_defined_flag <= 4'h0;
        tick(3);
        chk(warning_word, 32'h0);
        acc(1'b0, edi_pkg::IDX_IRQ_STATUS, 32'h0, 32'h2, 1'b0);
        acc(1'b1, edi_pkg::IDX_IRQ_ENABLE, 32'h0, 32'h0, 1'b0);
        tick(2);
        chk(irq, 32'h0);
        acc(1'b1, edi_pkg::IDX_IRQ_CLEAR, 32'h2, 32'h0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            alarm_source <= i[1:0];
            tick(3);
            chk(alarm_word, {30'h0, i[1:0]});
        end
        for (int i = 0; i < 8; i++) begin
            acc(1'b1, edi_pkg::IDX_SUP_ALARM + 16'(i), 32'hFFFFFFFF, 32'h0, 1'b1);
        end
        acc(1'b0, edi_pkg::IDX_SUP_ALARM, 32'h0, 32'h00001000, 1'b0);
        acc(1'b0, edi_pkg::IDX_OP_TIME, 32'h0, 32'h0FFFFFFF, 1'b0);
        acc(1'b0, edi_pkg::IDX_IRQ_STATUS, 32'h0, 32'h4, 1'b0);
        report_and_stop();
    end
endmodule : test_encoder_diag_ident_objects
`default_nettype wire
